// file: design/tfc_bypass.sv
`timescale 1ns/1ps
`default_nettype none

module tfc_bypass
    import tfc_pkg::*;
(
    // link clock
    input  wire logic link_clk_i,
    // core side
    input  wire logic sys_rst_i,
    input  wire logic blown_i,
    // link side
    input  wire logic tdi_i,
    input  wire logic user_tdo_i,
    output logic      tdo_o,
    output logic      bypass_o
);

    // ------------------------------------------------------------
    // crossings into the link domain
    // ------------------------------------------------------------
    logic link_rst;
    logic blown_s;

    tfc_sync #(.WIDTH(1), .RST_VAL(LINK_RST_VAL)) u_rst_sync (
        .clk_i   (link_clk_i),
        .rst_i   (1'b0),
        .async_i (sys_rst_i),
        .sync_o  (link_rst)
    );

    tfc_sync #(.WIDTH(1), .RST_VAL(BLOWN_RST)) u_blown_sync (
        .clk_i   (link_clk_i),
        .rst_i   (link_rst),
        .async_i (blown_i),
        .sync_o  (blown_s)
    );

    // ------------------------------------------------------------
    // bypass path
    // ------------------------------------------------------------
    logic tdi_q;
    logic bypass_d;
    logic tdo_d;

    assign bypass_d = bypass_o | blown_s;
    assign tdo_d    = bypass_d ? tdi_q : user_tdo_i;

    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            tdi_q    <= 1'b0;
            bypass_o <= 1'b0;
            tdo_o    <= 1'b0;
        end else begin
            tdi_q    <= tdi_i;
            bypass_o <= bypass_d;
            tdo_o    <= tdo_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_bypass_enter;
        @(posedge link_clk_i) disable iff (link_rst)
        blown_s |=> bypass_o ##0 (tdo_o == $past(tdi_q));
    endproperty
    a_bypass_enter: assert property (p_bypass_enter) else $error("blown fuse did not force bypass");

    property p_bypass_stays;
        @(posedge link_clk_i) disable iff (link_rst)
        bypass_o |=> bypass_o [*4];
    endproperty
    a_bypass_stays: assert property (p_bypass_stays) else $error("bypass released before reset");

endmodule

`default_nettype wire

// file: design/tfc_fuse_check.sv
`timescale 1ns/1ps
`default_nettype none

module tfc_fuse_check
    import tfc_pkg::*;
(
    // core clock and reset
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    // link clock
    input  wire logic link_clk_i,
    // test pins
    input  wire logic tms_i,
    input  wire logic test_i,
    input  wire logic tdi_i,
    input  wire logic user_tdo_i,
    output logic      tdo_o,
    // fuse
    input  wire logic fuse_ok_i,
    output logic      sense_en_o,
    // status
    output logic      mode_active_o,
    output logic      fuse_blown_o,
    output logic      bypass_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_vec;
    tfc_pins_t        pins_s;

    assign pins_raw = {tms_i, test_i, fuse_ok_i};

    // reset values keep a quiet link from looking like an edge,
    // except a low tms at release, which is wanted as one
    tfc_sync #(.WIDTH(PIN_W), .RST_VAL(PINS_RST)) u_pin_sync (
        .clk_i   (core_clk_i),
        .rst_i   (sys_rst_i),
        .async_i (pins_raw),
        .sync_o  (pins_vec)
    );

    assign pins_s = pins_vec;

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    logic tms_prev_q;
    logic test_prev_q;
    logic tms_fall;
    logic tms_rise;
    logic test_fall;

    assign tms_fall  = tms_prev_q & ~pins_s.tms;
    assign tms_rise  = ~tms_prev_q & pins_s.tms;
    assign test_fall = test_prev_q & ~pins_s.test;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tms_prev_q  <= PINS_RST.tms;
            test_prev_q <= PINS_RST.test;
        end else begin
            tms_prev_q  <= pins_s.tms;
            test_prev_q <= pins_s.test;
        end
    end

    // ------------------------------------------------------------
    // rising edge count
    // ------------------------------------------------------------
    logic [1:0] rise_cnt_q;
    logic [1:0] rise_cnt_d;
    logic       rise_sat;

    // saturate so a long session cannot wrap and re-arm
    assign rise_sat   = (rise_cnt_q == RISE_EXIT);
    assign rise_cnt_d = (tms_rise && !rise_sat) ? rise_cnt_q + 2'h1 : rise_cnt_q;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rise_cnt_q <= RISE_CNT_RST;
        end else begin
            rise_cnt_q <= rise_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // mode state machine
    // ------------------------------------------------------------
    tfc_state_t state_q;
    tfc_state_t state_d;
    logic       exit_edge;

    assign exit_edge = tms_rise && (rise_cnt_q == RISE_EXIT - 2'h1);

    always_comb begin
        state_d = state_q;
        case (state_q)
            TFC_ARMED: begin
                // low at release shows as a fall
                if (tms_fall && !rise_sat) begin
                    state_d = TFC_ACTIVE;
                end
            end
            TFC_ACTIVE: begin
                if (exit_edge || test_fall) begin
                    state_d = TFC_DONE;
                end
            end
            TFC_DONE: begin
                state_d = TFC_DONE;
            end
            default: begin
                state_d = TFC_DONE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_q <= STATE_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // sense sink and status
    // ------------------------------------------------------------
    logic active_d;
    logic sense_d;
    logic blown_d;

    assign active_d = (state_d == TFC_ACTIVE);
    assign sense_d  = active_d & ~pins_s.tms & pins_s.fuse_ok;
    // a blown fuse never heals, so keep it sticky against glitches
    assign blown_d  = fuse_blown_o | ~pins_s.fuse_ok;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            mode_active_o <= 1'b0;
            sense_en_o    <= 1'b0;
            fuse_blown_o  <= BLOWN_RST;
        end else begin
            mode_active_o <= active_d;
            sense_en_o    <= sense_d;
            fuse_blown_o  <= blown_d;
        end
    end

    // ------------------------------------------------------------
    // link side bypass
    // ------------------------------------------------------------
    // blown status crosses to the link clock
    tfc_bypass u_bypass (
        .link_clk_i (link_clk_i),
        .sys_rst_i  (sys_rst_i),
        .blown_i    (fuse_blown_o),
        .tdi_i      (tdi_i),
        .user_tdo_i (user_tdo_i),
        .tdo_o      (tdo_o),
        .bypass_o   (bypass_o)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_left;
        !mode_active_o ##1 !sense_en_o;
    endsequence

    sequence s_quiet_done;
        (state_q == TFC_DONE) && !mode_active_o && !sense_en_o;
    endsequence

    property p_enter;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_q == TFC_ARMED && tms_fall && rise_cnt_q == 2'h0) |=> mode_active_o;
    endproperty
    a_enter: assert property (p_enter) else $error("falling edge did not enter mode");

    property p_low_start;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_q == TFC_ARMED && rise_cnt_q == 2'h0 && !pins_s.tms)
            |=> mode_active_o ##1 (mode_active_o || $past(tms_rise) || $past(test_fall));
    endproperty
    a_low_start: assert property (p_low_start) else $error("low select at start not active");

    property p_exit;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_q == TFC_ACTIVE && tms_rise && rise_cnt_q == 2'h1) |=> s_left;
    endproperty
    a_exit: assert property (p_exit) else $error("second rising edge did not leave");

    property p_no_reentry;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_q == TFC_DONE) |=> s_quiet_done [*3];
    endproperty
    a_no_reentry: assert property (p_no_reentry) else $error("mode re-entered without reset");

    property p_sense_gate;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        sense_en_o |-> mode_active_o && !$past(pins_s.tms);
    endproperty
    a_sense_gate: assert property (p_sense_gate) else $error("sense on outside active low select");

    property p_sense_follow;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (active_d && !pins_s.tms && pins_s.fuse_ok) |=> sense_en_o;
    endproperty
    a_sense_follow: assert property (p_sense_follow) else $error("sense not enabled when due");

    property p_fuse_blown;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        !pins_s.fuse_ok |=> !sense_en_o && fuse_blown_o;
    endproperty
    a_fuse_blown: assert property (p_fuse_blown) else $error("sense current with blown fuse");

    property p_test_low;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_q == TFC_ACTIVE && test_fall) |=> s_left;
    endproperty
    a_test_low: assert property (p_test_low) else $error("test pin low did not end mode");

    property p_reset_clear;
        @(posedge core_clk_i) disable iff (1'b0)
        sys_rst_i |=> (state_q == TFC_ARMED) && (rise_cnt_q == 2'h0) && !mode_active_o && !sense_en_o;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear mode state");

    property p_blown_sticky;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        fuse_blown_o |=> fuse_blown_o;
    endproperty
    a_blown_sticky: assert property (p_blown_sticky) else $error("blown status released");

    property p_one_rise_stays;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_q == TFC_ACTIVE && tms_rise && rise_cnt_q == 2'h0 && !test_fall) |=> mode_active_o;
    endproperty
    a_one_rise_stays: assert property (p_one_rise_stays) else $error("first rising edge left the mode");

    property p_rise_count;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (tms_rise && !rise_sat) |=> (rise_cnt_q == $past(rise_cnt_q) + 2'h1);
    endproperty
    a_rise_count: assert property (p_rise_count) else $error("rising edge not counted");

    property p_done_holds;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_q == TFC_DONE) |=> (state_q == TFC_DONE);
    endproperty
    a_done_holds: assert property (p_done_holds) else $error("done state left without reset");

    property p_enter_sense;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_q == TFC_ARMED && tms_fall && !rise_sat && pins_s.fuse_ok) |=> sense_en_o;
    endproperty
    a_enter_sense: assert property (p_enter_sense) else $error("sink not enabled on entry");

    property p_sense_off_high;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        pins_s.tms |=> !sense_en_o;
    endproperty
    a_sense_off_high: assert property (p_sense_off_high) else $error("sink on while select high");

    property p_sense_fuse;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        sense_en_o |-> $past(pins_s.fuse_ok);
    endproperty
    a_sense_fuse: assert property (p_sense_fuse) else $error("sink on without intact fuse");

    property p_test_fall_quiet;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_q != TFC_ARMED && test_fall) |=> !mode_active_o && !sense_en_o;
    endproperty
    a_test_fall_quiet: assert property (p_test_fall_quiet) else $error("test pin drop left sink on");

endmodule

`default_nettype wire

// file: design/tfc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module tfc_sync
    import tfc_pkg::*;
#(
    parameter int             WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // ------------------------------------------------------------
    // two stage synchroniser
    // ------------------------------------------------------------
    // first stage is read only by the second stage
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

`default_nettype wire

// file: include/tfc_pkg.sv
`default_nettype none

package tfc_pkg;

    // ------------------------------------------------------------
    // fuse check state machine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TFC_ARMED  = 2'b00,
        TFC_ACTIVE = 2'b01,
        TFC_DONE   = 2'b10
    } tfc_state_t;

    // ------------------------------------------------------------
    // pin group as seen by the core after synchronising
    // ------------------------------------------------------------
    typedef struct packed {
        logic tms;
        logic test;
        logic fuse_ok;
    } tfc_pins_t;

    localparam int PIN_W = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    // tms idles high, test idles low (pulled down), fuse assumed intact
    localparam tfc_pins_t PINS_RST      = '{tms: 1'b1, test: 1'b0, fuse_ok: 1'b1};
    localparam tfc_state_t STATE_RST    = TFC_ARMED;
    localparam logic [1:0] RISE_CNT_RST = 2'h0;
    localparam logic       BLOWN_RST    = 1'b0;
    localparam logic       LINK_RST_VAL = 1'b1;

    // ------------------------------------------------------------
    // counts
    // ------------------------------------------------------------
    localparam logic [1:0] RISE_EXIT    = 2'h2;
    localparam int         SYNC_STAGES  = 2;

endpackage

`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import tfc_pkg::*;

    logic core_clk_i;
    logic sys_rst_i;
    wire logic link_clk;
    wire logic tms;
    wire logic test;
    wire logic tdi;
    wire logic user_tdo;
    wire logic fuse_ok;
    logic tdo;
    logic sense_en;
    logic mode_active;
    logic fuse_blown;
    logic bypass;
    int   bad_count;
    int   checked;

    tfc_fuse_check dut_u (
        .core_clk_i    (core_clk_i),
        .sys_rst_i     (sys_rst_i),
        .link_clk_i    (link_clk),
        .tms_i         (tms),
        .test_i        (test),
        .tdi_i         (tdi),
        .user_tdo_i    (user_tdo),
        .tdo_o         (tdo),
        .fuse_ok_i     (fuse_ok),
        .sense_en_o    (sense_en),
        .mode_active_o (mode_active),
        .fuse_blown_o  (fuse_blown),
        .bypass_o      (bypass)
    );

    tfc_tool_model tool_u (
        .core_clk_i (core_clk_i),
        .link_clk_o (link_clk),
        .tms_o      (tms),
        .test_o     (test),
        .tdi_o      (tdi),
        .user_tdo_o (user_tdo),
        .fuse_ok_o  (fuse_ok)
    );

    // ------------------------------------------------------------
    // clock and bookkeeping
    // ------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic results;
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // reset is stretched so the link side sees enough of its own edges
    task automatic do_reset(input logic tms_v);
        @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        tool_u.set_pins(tms_v, 1'b0, 1'b1);
        tool_u.frame(4, 1'b0);
        chk(mode_active, 1'b0, "mode in reset");
        chk(sense_en, 1'b0, "sink in reset");
        @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        #1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_enter_exit;
        do_reset(1'b1);
        chk(mode_active, 1'b0, "idle after reset");
        tool_u.set_pins(1'b0, 1'b0, 1'b1);
        chk(mode_active, 1'b1, "first fall enters");
        chk(sense_en, 1'b1, "sink on while low");
        tool_u.set_pins(1'b1, 1'b0, 1'b1);
        chk(sense_en, 1'b0, "sink off while high");
        chk(mode_active, 1'b1, "one rise keeps mode");
        tool_u.set_pins(1'b0, 1'b0, 1'b1);
        chk(sense_en, 1'b1, "sink back on");
        tool_u.set_pins(1'b1, 1'b0, 1'b1);
        chk(mode_active, 1'b0, "second rise exits");
        tool_u.set_pins(1'b0, 1'b0, 1'b1);
        chk(mode_active, 1'b0, "no re-entry");
        chk(sense_en, 1'b0, "no sink after exit");
    endtask

    task automatic s_low_at_power_up;
        do_reset(1'b0);
        chk(mode_active, 1'b1, "low at power up enters");
        chk(sense_en, 1'b1, "reset re-arms sink");
    endtask

    task automatic s_test_drop;
        do_reset(1'b1);
        tool_u.set_pins(1'b1, 1'b1, 1'b1);
        tool_u.set_pins(1'b0, 1'b1, 1'b1);
        chk(mode_active, 1'b1, "enter with test high");
        tool_u.set_pins(1'b0, 1'b0, 1'b1);
        chk(mode_active, 1'b0, "test drop ends mode");
        chk(sense_en, 1'b0, "test drop ends sink");
    endtask

    task automatic s_fuse_blow;
        do_reset(1'b1);
        tool_u.frame(4, 1'b1);
        chk(bypass, 1'b0, "no bypass intact");
        chk(tdo, 1'b0, "normal path out");
        tool_u.set_pins(1'b0, 1'b0, 1'b1);
        chk(sense_en, 1'b1, "sink with intact fuse");
        tool_u.set_pins(1'b0, 1'b0, 1'b0);
        chk(sense_en, 1'b0, "no sink when blown");
        chk(fuse_blown, 1'b1, "blown flag");
        tool_u.frame(6, 1'b1);
        chk(bypass, 1'b1, "bypass after blow");
        chk(tdo, 1'b1, "bypass passes one");
        tool_u.frame(6, 1'b0);
        chk(tdo, 1'b0, "bypass passes zero");
        tool_u.set_pins(1'b0, 1'b0, 1'b1);
        chk(fuse_blown, 1'b1, "blown is sticky");
    endtask

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        sys_rst_i = 1'b1;
        bad_count = 0;
        checked   = 0;
        repeat (4) @(posedge core_clk_i);
        s_enter_exit();
        s_low_at_power_up();
        s_test_drop();
        s_fuse_blow();
        results();
    end

    initial begin
        #200us;
        bad_count++;
        $display("wrong value at %0t: run did not finish", $time);
        results();
    end
endmodule

`default_nettype wire

// file: verification/tfc_tool_model.sv
`timescale 1ns/1ps
`default_nettype none

module tfc_tool_model (
    // core clock, pins change just after its edge
    input  wire logic core_clk_i,
    // pins toward the device
    output logic      link_clk_o,
    output logic      tms_o,
    output logic      test_o,
    output logic      tdi_o,
    output logic      user_tdo_o,
    output logic      fuse_ok_o
);
    // ------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------
    // mode select idles high
    initial begin
        link_clk_o = 1'b0;
        tms_o      = 1'b1;
        test_o     = 1'b0;
        tdi_o      = 1'b0;
        user_tdo_o = 1'b1;
        fuse_ok_o  = 1'b1;
    end

    // ------------------------------------------------------------
    // pin levels, then long enough for the 3-edge answer to land
    // ------------------------------------------------------------
    task automatic set_pins(input logic tms_v, input logic test_v, input logic fuse_v);
        @(posedge core_clk_i);
        tms_o     <= tms_v;
        test_o    <= test_v;
        fuse_ok_o <= fuse_v;
        repeat (5) @(posedge core_clk_i);
        #1;
    endtask

    // ------------------------------------------------------------
    // link frame: clock runs only here, data held for the whole frame
    // ------------------------------------------------------------
    task automatic frame(input int n, input logic bit_v);
        #3.1;
        tdi_o      = bit_v;
        user_tdo_o = ~bit_v;
        for (int i = 0; i < n; i++) begin
            #62.5 link_clk_o = 1'b1;
            #62.5 link_clk_o = 1'b0;
        end
        // released data line must not look like the last bit
        tdi_o = ~bit_v;
        #1;
    endtask
endmodule

`default_nettype wire
